//--- core/led_seq_pkg.sv
// constants, register map and state codes for the LED buck channel sequencer
// assumes a single 250 MHz core clock; all pins arrive asynchronously
package led_seq_pkg;
	localparam int unsigned NCH = 2;
	localparam int unsigned SYNC_W = 24;
	localparam int unsigned CLK_PERIOD_NS = 4;
	// free-running switching period
	localparam int unsigned OSC_PERIOD_NS = 1000;
	localparam int unsigned OSC_CYC = OSC_PERIOD_NS / CLK_PERIOD_NS;
	// boost capacitor refresh on-time of the bottom switch (least time)
	localparam int unsigned REFRESH_NS = 200;
	localparam int unsigned REFRESH_CYC =
		(REFRESH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// delay from enable to the disconnect gate going low (least time)
	localparam int unsigned PMOS_DELAY_NS = 100;
	localparam int unsigned PMOS_DELAY_CYC =
		(PMOS_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// start-up blanking of short detection
	localparam int unsigned STARTUP_BLANK_NS = 100000;
	localparam int unsigned STRAP_SETTLE = 3;
	localparam int unsigned SEQ_CNT_W = 8;
	localparam int unsigned BLANK_CNT_W = 24;

	localparam logic [6:0] I2C_DEV_ADDR = 7'h60;
	localparam logic [7:0] REG_STATUS = 8'h00;
	localparam logic [7:0] REG_CONFIG = 8'h01;
	localparam logic [7:0] REG_DUTY1 = 8'h02;
	localparam logic [7:0] REG_DUTY2 = 8'h03;
	localparam logic [7:0] REG_CHANNEL1_ANALOG_DIM_LEVEL = 8'h04;

	localparam logic [7:0] CONFIG_RESET = 8'h00;
	localparam logic [7:0] DUTY_RESET = 8'h00;
	localparam logic [7:0] ADIM_RESET = 8'hFF;
	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam int unsigned CFG_CLKOUT_BIT = 6;

	// status bit positions within one channel's nibble
	localparam int unsigned ST_OVFB = 0;
	localparam int unsigned ST_OPEN = 1;
	localparam int unsigned ST_SHORT = 2;
	localparam int unsigned ST_OVCUR = 3;
	localparam int unsigned ST_STRIDE = 4;

	typedef enum logic [4:0] {
		CH_OFF = 5'h01,
		CH_REFRESH = 5'h02,
		CH_TOP = 5'h04,
		CH_BOTTOM = 5'h08,
		CH_SKIP = 5'h10
	} chan_state_e;

	typedef enum logic [4:0] {
		I_IDLE = 5'h01,
		I_ADDR = 5'h02,
		I_PTR = 5'h04,
		I_WDATA = 5'h08,
		I_RDATA = 5'h10
	} i2c_state_e;
endpackage : led_seq_pkg

//--- core/led_buck_channel_sequencer.sv
// two-channel buck LED sequencer: switch order, disconnect gate, faults, I2C
// assumes analog comparators deliver levels on pins; scl/sda are open drain
`timescale 1ns/1ns

// Function
// [R01] dim input or channel_on low: both switches off, disconnect gate high.
// [R02] dim and channel_on high: disconnect gate goes low after a short delay.
// [R03] on enable, bottom switch refreshes boost capacitor before top turns on.
// [R04] cycle starts on oscillator set pulse; current trip ends top on-time.
// [R05] bottom switch stays on until next cycle or zero inductor current.
// [R06] bottom switch overcurrent delays next cycle until current is safe.
// [R07] open-string flag: feedback near regulation while sense below 10mV.
// [R08] shorted-string flag: feedback below 0.25V after start-up.
// [R09] short detection blanked for a period after enable input rises.
// [R10] any channel fault drives its disconnect gate high; the open-string flag alone leaves the gate low.
// [R11] status over I2C: overvoltage, short, overcurrent, open string.
// [R12] bus mode unless both address-select pins grounded.
// [R13] bus mode stays idle until a dimming-duty write arrives.
// [R14] stand-alone mode starts on first dim input rising edge.
// [R15] stand-alone answers address 1100000; duty registers not writable.
// [R16] sense threshold scaled by (channel1_dim_code+1)/256 in analog stage.
// [R17] analog dim code resets to 255.
// [R18] external sync clock duty 20..60 percent, RT set 10 percent below.
// [R19] clock output disabled after reset, enabled by configuration bit 6.
// [R20] alert stays asserted until all conditions gone and unlatched.
// [R21] channel 1 faults in status bits 1,2; channel 2 in bits 5,6.
// [R22] channel_on from duty register in bus mode, high in stand-alone.
module led_buck_channel_sequencer
	import led_seq_pkg::*;
#(
	parameter int unsigned BLANK_CYCLES = STARTUP_BLANK_NS / CLK_PERIOD_NS
) (
	input wire logic clk, // core clock
	input wire logic arst_n, // async reset, active low
	input wire logic [1:0] dim_in, // dimming inputs per channel
	input wire logic [1:0] fb_near_reg, // feedback within 53mV of reg
	input wire logic [1:0] sense_low, // sense voltage below 10mV
	input wire logic [1:0] fb_short, // feedback below 0.25V
	input wire logic [1:0] fb_over, // feedback above 1.233V
	input wire logic [1:0] sense_over, // sense voltage above 930mV
	input wire logic [1:0] switch_trip, // switch current above error amp
	input wire logic [1:0] valley_over, // bottom switch current above 2A
	input wire logic [1:0] inductor_zero, // inductor current at zero
	input wire logic enable_undervoltage_input, // enable comparator level
	input wire logic bus_id_select_1_gnd, // address pin 1 grounded
	input wire logic bus_id_select_2_gnd, // address pin 2 grounded
	input wire logic scl_in, // I2C clock
	input wire logic sda_in, // I2C data level
	output logic sda_out, // I2C data drive value
	output logic sda_oe_n, // I2C data pull-down enable
	input wire logic freq_lock_in, // sync pin level
	output logic freq_lock_out, // sync pin clock output
	output logic freq_lock_oe_n, // sync pin drive enable
	output logic alert_out, // alert drive value
	output logic alert_oe_n, // alert pull-down enable
	output logic [1:0] top_switch_on, // top power switch gates
	output logic [1:0] bottom_switch_on, // bottom power switch gates
	output logic [1:0] load_disconnect_gate, // high keeps PMOS off
	output logic [7:0] channel1_dim_code // analog dim code to scaler
);
	logic [SYNC_W-1:0] raw_in, sync1, sync2;
	logic [1:0] d_dim, d_near, d_low, d_short, d_over, d_ocur;
	logic [1:0] d_trip, d_valley, d_zero;
	logic d_en, d_scl, d_sda, d_lock, d_gnd1, d_gnd2;
	logic p_scl, p_sda, p_en, p_lock;
	logic [1:0] p_dim;
	logic scl_rise, scl_fall, i2c_start, i2c_stop, en_rise, lock_rise;
	logic [1:0] dim_rise;

	assign raw_in = {dim_in, fb_near_reg, sense_low, fb_short, fb_over,
		sense_over, switch_trip, valley_over, inductor_zero,
		enable_undervoltage_input, scl_in, sda_in, freq_lock_in,
		bus_id_select_1_gnd, bus_id_select_2_gnd};
	assign {d_dim, d_near, d_low, d_short, d_over, d_ocur, d_trip,
		d_valley, d_zero, d_en, d_scl, d_sda, d_lock, d_gnd1,
		d_gnd2} = sync2;

	// two-flop synchronisers for every pin
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			sync1 <= '0;
			sync2 <= '0;
		end else begin
			sync1 <= raw_in;
			sync2 <= sync1;
		end
	end

	// previous values for edge detection, read only from the second stage
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			p_scl <= 1'b1;
			p_sda <= 1'b1;
			p_en <= 1'b0;
			p_lock <= 1'b0;
			p_dim <= 2'b00;
		end else begin
			p_scl <= d_scl;
			p_sda <= d_sda;
			p_en <= d_en;
			p_lock <= d_lock;
			p_dim <= d_dim;
		end
	end

	assign scl_rise = d_scl & ~p_scl;
	assign scl_fall = ~d_scl & p_scl;
	assign i2c_start = d_scl & p_scl & p_sda & ~d_sda;
	assign i2c_stop = d_scl & p_scl & ~p_sda & d_sda;
	assign en_rise = d_en & ~p_en;
	assign lock_rise = d_lock & ~p_lock;
	assign dim_rise = d_dim & ~p_dim;

	// mode strap caught once the synchronisers have settled
	logic [1:0] strap_cnt;
	logic strap_done, standalone;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			strap_cnt <= 2'd0;
			strap_done <= 1'b0;
			standalone <= 1'b0;
		end else if (!strap_done) begin
			strap_cnt <= strap_cnt + 2'd1;
			if (strap_cnt == 2'(STRAP_SETTLE)) begin
				strap_done <= 1'b1;
				standalone <= d_gnd1 & d_gnd2; // [R12]
			end
		end
	end

	// I2C slave
	i2c_state_e i2c_st;
	logic [3:0] bitcnt;
	logic [7:0] rx, tx, ptr, wr_data, rd_val;
	logic sda_drive, wr_stb, rd_stb;
	logic [7:0] config_reg, status;
	logic [7:0] duty [NCH];

	always_comb begin
		case (ptr)
			REG_STATUS: rd_val = status; // [R11]
			REG_CONFIG: rd_val = config_reg;
			REG_DUTY1: rd_val = duty[0];
			REG_DUTY2: rd_val = duty[1];
			REG_CHANNEL1_ANALOG_DIM_LEVEL: rd_val = channel1_dim_code;
			default: rd_val = 8'h00;
		endcase
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			i2c_st <= I_IDLE;
			bitcnt <= 4'd0;
			rx <= 8'h00;
			tx <= 8'h00;
			ptr <= 8'h00;
			wr_data <= 8'h00;
			sda_drive <= 1'b0;
			wr_stb <= 1'b0;
			rd_stb <= 1'b0;
		end else begin
			wr_stb <= 1'b0;
			rd_stb <= 1'b0;
			if (i2c_start) begin
				i2c_st <= I_ADDR;
				bitcnt <= 4'd0;
				sda_drive <= 1'b0;
			end else if (i2c_stop) begin
				i2c_st <= I_IDLE;
				sda_drive <= 1'b0;
			end else if (i2c_st != I_IDLE && scl_rise) begin
				if (bitcnt < 4'd8) begin
					rx <= {rx[6:0], d_sda};
					bitcnt <= bitcnt + 4'd1;
				end else begin
					bitcnt <= 4'd9;
					if (i2c_st == I_RDATA && d_sda)
						i2c_st <= I_IDLE;
				end
			end else if (i2c_st != I_IDLE && scl_fall) begin
				if (bitcnt == 4'd8) begin
					case (i2c_st)
						I_ADDR: begin
							if (rx[7:1] == I2C_DEV_ADDR) // [R15]
								sda_drive <= 1'b1;
							else
								i2c_st <= I_IDLE;
						end
						I_PTR: begin
							sda_drive <= 1'b1;
							ptr <= rx;
						end
						I_WDATA: begin
							sda_drive <= 1'b1;
							wr_stb <= 1'b1;
							wr_data <= rx;
						end
						default: sda_drive <= 1'b0;
					endcase
				end else if (bitcnt == 4'd9) begin
					bitcnt <= 4'd0;
					case (i2c_st)
						I_ADDR: begin
							if (rx[0]) begin
								i2c_st <= I_RDATA;
								tx <= rd_val;
								sda_drive <= ~rd_val[7];
								rd_stb <= 1'b1;
							end else begin
								i2c_st <= I_PTR;
								sda_drive <= 1'b0;
							end
						end
						I_RDATA: begin
							tx <= rd_val;
							sda_drive <= ~rd_val[7];
							rd_stb <= 1'b1;
						end
						I_PTR: begin
							i2c_st <= I_WDATA;
							sda_drive <= 1'b0;
						end
						default: sda_drive <= 1'b0;
					endcase
				end else if (i2c_st == I_RDATA && bitcnt != 4'd0) begin
					tx <= {tx[6:0], 1'b0};
					sda_drive <= ~tx[6];
				end
			end
		end
	end

	assign sda_out = 1'b0;
	assign sda_oe_n = ~sda_drive;

	// writable registers; duty writes refused in stand-alone mode
	logic duty_wr;
	assign duty_wr = wr_stb && !standalone
		&& (ptr == REG_DUTY1 || ptr == REG_DUTY2); // [R15]
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			config_reg <= CONFIG_RESET;
			channel1_dim_code <= ADIM_RESET; // [R17]
			duty[0] <= DUTY_RESET;
			duty[1] <= DUTY_RESET;
		end else if (wr_stb) begin
			if (ptr == REG_CONFIG)
				config_reg <= wr_data;
			if (ptr == REG_CHANNEL1_ANALOG_DIM_LEVEL)
				channel1_dim_code <= wr_data; // [R16]
			if (duty_wr && ptr == REG_DUTY1)
				duty[0] <= wr_data;
			if (duty_wr && ptr == REG_DUTY2)
				duty[1] <= wr_data;
		end
	end

	// start permission per mode
	logic started;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			started <= 1'b0;
		else if (strap_done && !standalone && duty_wr)
			started <= 1'b1; // [R13]
		else if (strap_done && standalone && |dim_rise)
			started <= 1'b1; // [R14]
	end

	// start-up blanking of short detection
	logic [BLANK_CNT_W-1:0] blank_cnt;
	logic blank_done;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			blank_cnt <= '0;
			blank_done <= 1'b0;
		end else if (!d_en || en_rise) begin
			blank_cnt <= '0; // [R09]
			blank_done <= 1'b0;
		end else if (!blank_done) begin
			blank_cnt <= blank_cnt + BLANK_CNT_W'(1);
			if (blank_cnt == BLANK_CNT_W'(BLANK_CYCLES - 1))
				blank_done <= 1'b1;
		end
	end

	// oscillator, restarted by external sync edges unless driving out
	logic [7:0] osc_cnt;
	logic set_pulse, clkout_en;
	assign clkout_en = config_reg[CFG_CLKOUT_BIT];
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			osc_cnt <= 8'h00;
			set_pulse <= 1'b0;
			freq_lock_out <= 1'b0;
			freq_lock_oe_n <= 1'b1;
		end else begin
			if ((!clkout_en && lock_rise)
				|| osc_cnt == 8'(OSC_CYC - 1)) begin
				osc_cnt <= 8'h00;
				set_pulse <= 1'b1;
			end else begin
				osc_cnt <= osc_cnt + 8'h01;
				set_pulse <= 1'b0;
			end
			freq_lock_out <= osc_cnt < 8'(OSC_CYC / 2);
			freq_lock_oe_n <= ~clkout_en; // [R19]
		end
	end

	// per-channel sequencing
	logic [1:0] channel_on, fault_now, run, pend, start_go;
	logic [7:0] st_set;
	chan_state_e ch_st [NCH];
	logic [SEQ_CNT_W-1:0] seq_cnt [NCH];
	logic [SEQ_CNT_W-1:0] gate_cnt [NCH];

	for (genvar i = 0; i < NCH; i++) begin : g_ch
		assign channel_on[i] = standalone | (duty[i] != DUTY_RESET); // [R22]
		assign fault_now[i] = d_over[i] | d_ocur[i]
			| (d_short[i] & blank_done);
		assign run[i] = started & d_en & d_dim[i] & channel_on[i]
			& ~fault_now[i]; // [R01] [R10]
		assign start_go[i] = pend[i] & ~d_valley[i]; // [R06]
		assign st_set[ST_STRIDE*i + ST_OVFB] = d_over[i];
		assign st_set[ST_STRIDE*i + ST_OPEN] = d_near[i] & d_low[i]; // [R07]
		assign st_set[ST_STRIDE*i + ST_SHORT] =
			d_short[i] & blank_done; // [R08] [R21]
		assign st_set[ST_STRIDE*i + ST_OVCUR] = d_ocur[i];
		assign top_switch_on[i] = (ch_st[i] == CH_TOP);
		assign bottom_switch_on[i] = (ch_st[i] == CH_REFRESH)
			|| (ch_st[i] == CH_BOTTOM);

		always_ff @(posedge clk or negedge arst_n) begin
			if (!arst_n)
				pend[i] <= 1'b0;
			else if (!run[i])
				pend[i] <= 1'b0;
			else
				pend[i] <= set_pulse | (pend[i] & ~start_go[i]); // [R04]
		end

		always_ff @(posedge clk or negedge arst_n) begin
			if (!arst_n) begin
				ch_st[i] <= CH_OFF;
				seq_cnt[i] <= '0;
			end else if (!run[i]) begin
				ch_st[i] <= CH_OFF; // [R01]
				seq_cnt[i] <= '0;
			end else begin
				case (ch_st[i])
					CH_OFF: ch_st[i] <= CH_REFRESH; // [R03]
					CH_REFRESH: begin
						seq_cnt[i] <= seq_cnt[i] + SEQ_CNT_W'(1);
						if (seq_cnt[i] == SEQ_CNT_W'(REFRESH_CYC - 1))
							ch_st[i] <= CH_TOP; // [R03]
					end
					CH_TOP: if (d_trip[i]) ch_st[i] <= CH_BOTTOM; // [R04]
					CH_BOTTOM: begin
						if (start_go[i])
							ch_st[i] <= CH_TOP; // [R05]
						else if (d_zero[i])
							ch_st[i] <= CH_SKIP; // [R05]
					end
					CH_SKIP: if (start_go[i]) ch_st[i] <= CH_TOP;
					default: ch_st[i] <= CH_OFF;
				endcase
			end
		end

		always_ff @(posedge clk or negedge arst_n) begin
			if (!arst_n) begin
				load_disconnect_gate[i] <= 1'b1;
				gate_cnt[i] <= '0;
			end else if (!run[i]) begin
				load_disconnect_gate[i] <= 1'b1; // [R01] [R10]
				gate_cnt[i] <= '0;
			end else if (gate_cnt[i] == SEQ_CNT_W'(PMOS_DELAY_CYC - 1)) begin
				load_disconnect_gate[i] <= 1'b0; // [R02]
			end else begin
				gate_cnt[i] <= gate_cnt[i] + SEQ_CNT_W'(1);
			end
		end
	end

	// sticky status, cleared when read; a new event wins over the clear
	logic status_clr;
	assign status_clr = rd_stb && ptr == REG_STATUS;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			status <= STATUS_RESET;
		else if (status_clr)
			status <= st_set; // [R11]
		else
			status <= status | st_set; // [R11]
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			alert_oe_n <= 1'b1;
		else
			alert_oe_n <= ~(|status | |st_set); // [R20]
	end
	assign alert_out = 1'b0;
endmodule : led_buck_channel_sequencer

//--- verification/led_seq_properties.sv
// assertions on channel 1 sequencing, gating and reset values
// bound to the sequencer top and sees its ports only
`timescale 1ns/1ns
module led_seq_properties (
	input wire logic clk, // core clock
	input wire logic arst_n, // reset
	input wire logic [1:0] dim_in, // dim inputs
	input wire logic [1:0] fb_over, // overvoltage
	input wire logic [1:0] switch_trip, // current trip
	input wire logic [1:0] valley_over, // valley limit
	input wire logic freq_lock_oe_n, // clock out enable
	input wire logic [1:0] top_switch_on, // top gates
	input wire logic [1:0] bottom_switch_on, // bottom gates
	input wire logic [1:0] load_disconnect_gate, // pmos gates
	input wire logic [7:0] channel1_dim_code // dim code
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);
	wire off0 = !top_switch_on[0] && !bottom_switch_on[0];
	wire gate0 = load_disconnect_gate[0];
	sequence start0;
		off0 && gate0 ##1 !off0;
	endsequence
	sequence refresh0;
		(bottom_switch_on[0] && !top_switch_on[0]) [*8]
			##40 bottom_switch_on[0];
	endsequence
	chk_dim_low_off: assert property (
		!dim_in[0] [*5] |-> off0 && gate0)
		else $error("channel 1 active with dim low");
	chk_gate_delay: assert property (
		start0 |-> gate0 [*8] ##[12:20] !gate0)
		else $error("disconnect gate delay wrong");
	chk_refresh_first: assert property (
		start0 |-> refresh0 ##[1:6] top_switch_on[0])
		else $error("no boost refresh before top switch");
	chk_trip_ends_top: assert property (
		top_switch_on[0] && $rose(switch_trip[0])
			|-> ##[2:6] !top_switch_on[0])
		else $error("top switch ignores current trip");
	chk_bottom_after: assert property (
		$fell(top_switch_on[0]) && !gate0 |-> bottom_switch_on[0])
		else $error("bottom switch off after top turn-off");
	chk_valley_holds: assert property (
		valley_over[0] [*4] |-> !$rose(top_switch_on[0]))
		else $error("cycle started during valley overcurrent");
	chk_fault_gate: assert property (
		fb_over[0] [*5] |-> off0 && gate0)
		else $error("channel 1 not isolated on fault");
	chk_reset_values: assert property (
		!$past(arst_n) |-> freq_lock_oe_n && channel1_dim_code == 8'hFF)
		else $error("clock out or dim code wrong after reset");
endmodule : led_seq_properties

bind led_buck_channel_sequencer led_seq_properties chk (.*);

//--- verification/power_stage_model.sv
// behavioural power stage: current trip, zero current and valley limit
// follows the gate outputs; overload is commanded by the bench
`timescale 1ns/1ns
module power_stage_model #(
	parameter int TON = 30, // top on-time until current trip
	parameter int TZ = 150 // time after top off until zero current
) (
	input wire logic clk, // core clock
	input wire logic [1:0] top_on, // top gates
	input wire logic [1:0] bot_on, // bottom gates
	input wire logic [1:0] ovl, // overload commanded by the bench
	output logic [1:0] trip, // switch current above error amp
	output logic [1:0] izero, // inductor current at zero
	output logic [1:0] valley // bottom current above limit
);
	int cnt [2] = '{0, 0};
	logic [1:0] prev = 2'h0;
	initial trip = 2'h0;
	initial izero = 2'h0;
	initial valley = 2'h0;
	always @(posedge clk) begin
		prev <= top_on;
		for (int i = 0; i < 2; i++) begin
			cnt[i] <= (top_on[i] != prev[i]) ? 0 : cnt[i] + 1;
			trip[i] <= top_on[i] && cnt[i] >= TON;
			// overload keeps current up, so zero is never reached
			izero[i] <= bot_on[i] && !ovl[i] && cnt[i] >= TZ;
			valley[i] <= bot_on[i] && ovl[i];
		end
	end
endmodule : power_stage_model

//--- verification/testbench.sv
// bench: register access over I2C, channel sequencing, faults, modes
// drives pins 1 ns after a rising clock edge; power stage is modelled
`timescale 1ns/1ns
module testbench;
	import led_seq_pkg::*;
	logic clk = 0, arst_n = 0, en = 0, g1 = 0, g2 = 0, scl = 1, sda_m = 1;
	logic [1:0] dim = 2'h0, near = 2'h0, slow = 2'h0, shrt = 2'h0;
	logic [1:0] ovfb = 2'h0, ovcur = 2'h0, ovl = 2'h0;
	logic [1:0] trip, izero, valley, top, bot, gate;
	logic sda_out, sda_oe_n, fl_out, fl_oe_n, al_out, al_oe_n, a, top_d;
	logic fl_d, sync_on = 0, sync_ext = 0;
	logic [7:0] dcode, q, v;
	int n_errors = 0, compares = 0, rises = 0;
	int cyc = 0, last = 0, gap = 0, fl_rises = 0, sc = 0;
	wire sda_w = sda_m && (sda_oe_n || sda_out);
	// sync pin shows the bench clock unless the block drives it
	wire fl_w = fl_oe_n ? sync_ext : fl_out;
	always #2 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		top_d <= top[0];
		fl_d <= fl_w;
		if (top[0] && !top_d) begin
			rises++;
			gap = cyc - last;
			last = cyc;
		end
		if (fl_w && !fl_d)
			fl_rises++;
	end
	// external sync: 50% duty, about 10% faster than the free-running rate
	always @(posedge clk) begin
		#1;
		if (sync_on) begin
			sc = (sc == 113) ? 0 : sc + 1;
			if (sc == 0)
				sync_ext = ~sync_ext;
		end
	end
	led_buck_channel_sequencer #(.BLANK_CYCLES(20)) DUT (
		.clk(clk), .arst_n(arst_n), .dim_in(dim), .fb_near_reg(near),
		.sense_low(slow), .fb_short(shrt), .fb_over(ovfb),
		.sense_over(ovcur), .switch_trip(trip), .valley_over(valley),
		.inductor_zero(izero), .enable_undervoltage_input(en),
		.bus_id_select_1_gnd(g1), .bus_id_select_2_gnd(g2),
		.scl_in(scl), .sda_in(sda_w), .sda_out(sda_out),
		.sda_oe_n(sda_oe_n), .freq_lock_in(fl_w), .freq_lock_out(fl_out),
		.freq_lock_oe_n(fl_oe_n), .alert_out(al_out),
		.alert_oe_n(al_oe_n), .top_switch_on(top),
		.bottom_switch_on(bot), .load_disconnect_gate(gate),
		.channel1_dim_code(dcode));
	power_stage_model PS (.clk(clk), .top_on(top), .bot_on(bot),
		.ovl(ovl), .trip(trip), .izero(izero), .valley(valley));
	task automatic print_verdict();
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : print_verdict
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic chkb(input logic got, input logic exp);
		chk({7'h00, got}, {7'h00, exp});
	endtask : chkb
	task automatic wait_bot();
		int i;
		for (i = 0; i < 400 && bot[0] !== 1'b1; i++)
			tick(1);
		if (i == 400) begin
			n_errors++;
			$display("[ERR] %0t bottom switch never on", $time);
			print_verdict();
		end
	endtask : wait_bot
	// one scl period is 160 ns; sda moves only while scl is low
	task automatic bit_io(input logic b, output logic r);
		tick(5);
		sda_m = b;
		tick(15);
		scl = 1;
		tick(20);
		r = sda_w;
		scl = 0;
	endtask : bit_io
	task automatic start();
		sda_m = 1;
		tick(20);
		scl = 1;
		tick(20);
		sda_m = 0;
		tick(20);
		scl = 0;
	endtask : start
	task automatic stop();
		tick(5);
		sda_m = 0;
		tick(15);
		scl = 1;
		tick(20);
		sda_m = 1;
		tick(20);
	endtask : stop
	task automatic xfer(input logic [7:0] d, input logic m,
		output logic [7:0] r, output logic k);
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], r[i]);
		bit_io(m, k);
	endtask : xfer
	task automatic wr(input logic [7:0] p, input logic [7:0] d);
		start();
		xfer({I2C_DEV_ADDR, 1'b0}, 1'b1, q, a);
		chkb(a, 1'b0);
		xfer(p, 1'b1, q, a);
		xfer(d, 1'b1, q, a);
		chkb(a, 1'b0);
		stop();
	endtask : wr
	task automatic rd(input logic [7:0] p, output logic [7:0] r);
		start();
		xfer({I2C_DEV_ADDR, 1'b0}, 1'b1, q, a);
		xfer(p, 1'b1, q, a);
		start();
		xfer({I2C_DEV_ADDR, 1'b1}, 1'b1, q, a);
		xfer(8'hFF, 1'b1, r, a);
		stop();
	endtask : rd
	initial begin
		tick(8);
		arst_n = 1;
		en = 1;
		tick(12);
		chk(8'({top, bot, gate}), 8'h03);
		chkb(fl_oe_n, 1'b1);
		chk(dcode, 8'hFF);
		dim = 2'h3;
		tick(300);
		chk(8'({top, bot, gate}), 8'h03);
		rd(REG_CHANNEL1_ANALOG_DIM_LEVEL, v);
		chk(v, 8'hFF);
		wr(REG_CHANNEL1_ANALOG_DIM_LEVEL, 8'h5A);
		chk(dcode, 8'h5A);
		rd(8'h07, v);
		chk(v, 8'h00);
		chk(8'(fl_rises), 8'h00);
		wr(REG_CONFIG, 8'h40);
		chkb(fl_oe_n, 1'b0);
		wr(REG_DUTY1, 8'h80);
		wait_bot();
		tick(600);
		chkb(rises > 1, 1'b1);
		chkb(fl_rises > 1, 1'b1);
		chkb(gate[0], 1'b0);
		chk(8'({top[1], bot[1], gate[1]}), 8'h01);
		ovl[0] = 1;
		wait_bot();
		tick(60);
		rises = 0;
		tick(600);
		chk(8'(rises), 8'h00);
		ovl[0] = 0;
		tick(300);
		chkb(rises > 0, 1'b1);
		dim[0] = 0;
		tick(8);
		chk(8'({top[0], bot[0], gate[0]}), 8'h01);
		dim[0] = 1;
		wait_bot();
		chk(8'({top[0], gate[0]}), 8'h01);
		tick(100);
		ovfb[0] = 1;
		ovcur[0] = 1;
		near = 2'h3;
		slow = 2'h3;
		shrt[1] = 1;
		tick(8);
		chk(8'({top[0], bot[0], gate[0]}), 8'h01);
		chkb(al_oe_n, 1'b0);
		rd(REG_STATUS, v);
		chk(v, 8'h6B);
		{ovfb, ovcur, near, slow, shrt} = 10'h000;
		tick(8);
		chkb(al_oe_n, 1'b0);
		rd(REG_STATUS, v);
		chk(v, 8'h6B);
		rd(REG_STATUS, v);
		chk(v, 8'h00);
		tick(8);
		chkb(al_oe_n, 1'b1);
		arst_n = 0;
		{g1, g2, dim} = 4'hC;
		sync_on = 1;
		tick(4);
		arst_n = 1;
		tick(20);
		wr(REG_DUTY1, 8'h55);
		rd(REG_DUTY1, v);
		chk(v, 8'h00);
		chk(8'({top[0], bot[0]}), 8'h00);
		dim[0] = 1;
		wait_bot();
		chkb(top[0], 1'b0);
		tick(1000);
		chk(8'(gap), 8'hE4);
		dim[0] = 0;
		en = 0;
		tick(4);
		shrt[0] = 1;
		tick(4);
		en = 1;
		tick(8);
		chkb(al_oe_n, 1'b1);
		tick(30);
		chkb(al_oe_n, 1'b0);
		print_verdict();
	end
endmodule : testbench
